// ==== rbl_pkg.sv ====
package rbl_pkg;

  localparam logic [1:0]  MODE_DIRECT   = 2'h0;
  localparam logic [1:0]  MODE_FLASH    = 2'h1;
  localparam logic [1:0]  MODE_HOST     = 2'h2;
  localparam logic [1:0]  MODE_SPIMEM   = 2'h3;

  localparam logic [31:0] DIRECT_ADDR   = 32'h2000_0000;
  localparam logic [31:0] L1_BASE       = 32'hFFA0_0000;

  localparam logic [3:0]  EXT_HOLD_CYC  = 4'h3;
  localparam logic [3:0]  EXT_ACC_CYC   = 4'hF;
  localparam logic [3:0]  EXT_SETUP_CYC = 4'h4;

  localparam logic [3:0]  HDR_LEN       = 4'hA;
  localparam int          FLAG_LAST_BIT = 15;
  localparam int          PIN_ID_MSB    = 10;
  localparam int          PIN_ID_LSB    = 5;

  localparam logic [7:0]  CMD_READ      = 8'h03;
  localparam logic [7:0]  PROBE_ZERO    = 8'h00;
  localparam logic [7:0]  MISO_IDLE     = 8'hFF;
  localparam logic [3:0]  PROBE_MAX     = 4'h8;

  localparam logic [1:0]  SETTLE_CYC    = 2'h3;
  localparam int          CLK_PERIOD_NS = 10;
  localparam int          SPI_HALF_NS   = 40;
  localparam int          SPI_HALF_CYC  = (SPI_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [3:0] {
    S_RESET, S_SELECT, S_NEXT, S_SPI_WAIT, S_FL_SETUP, S_FL_ACCESS,
    S_FL_HOLD, S_HOST_WAIT, S_STORE, S_DONE, S_ERROR
  } rbl_state_e;

endpackage : rbl_pkg

// ==== rbl_spi_master.sv ====
`timescale 1ns/10ps
module rbl_spi_master
  import rbl_pkg::*;
#(
  parameter int HALF = SPI_HALF_CYC
) (
  input  wire logic       clk,
  input  wire logic       rstn,
  input  wire logic       abort,
  input  wire logic       start,
  input  wire logic [7:0] tx_byte,
  input  wire logic       miso_s,
  output logic            done,
  output logic [7:0]      rx_byte,
  output logic            sclk,
  output logic            mosi
);

  logic [7:0] cnt_r, cnt_nxt;
  logic [2:0] bit_r, bit_nxt;
  logic [7:0] sh_r,  sh_nxt;
  logic       busy_r, busy_nxt;
  logic       sclk_nxt, mosi_nxt, done_nxt;
  logic [7:0] rx_nxt;

  // mode 0; miso is sampled late in the high phase so the two-flop delay is hidden
  always_comb begin
    cnt_nxt  = cnt_r;
    bit_nxt  = bit_r;
    sh_nxt   = sh_r;
    busy_nxt = busy_r;
    sclk_nxt = sclk;
    mosi_nxt = mosi;
    done_nxt = 1'b0;
    rx_nxt   = rx_byte;
    if (abort) begin
      busy_nxt = 1'b0;
      sclk_nxt = 1'b0;
    end else if (!busy_r) begin
      if (start) begin
        sh_nxt   = tx_byte;
        mosi_nxt = tx_byte[7];
        busy_nxt = 1'b1;
        cnt_nxt  = 8'h00;
        bit_nxt  = 3'h0;
      end
    end else if (cnt_r == 8'(HALF - 1)) begin
      cnt_nxt = 8'h00;
      if (!sclk) begin
        sclk_nxt = 1'b1;
      end else begin
        sclk_nxt = 1'b0;
        sh_nxt   = {sh_r[6:0], miso_s};
        if (bit_r == 3'h7) begin
          busy_nxt = 1'b0;
          done_nxt = 1'b1;
          rx_nxt   = {sh_r[6:0], miso_s};
        end else begin
          bit_nxt  = bit_r + 3'h1;
          mosi_nxt = sh_r[6];
        end
      end
    end else begin
      cnt_nxt = cnt_r + 8'h01;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt_r   <= 8'h00;
      bit_r   <= 3'h0;
      sh_r    <= 8'h00;
      busy_r  <= 1'b0;
      sclk    <= 1'b0;
      mosi    <= 1'b0;
      done    <= 1'b0;
      rx_byte <= 8'h00;
    end else begin
      cnt_r   <= cnt_nxt;
      bit_r   <= bit_nxt;
      sh_r    <= sh_nxt;
      busy_r  <= busy_nxt;
      sclk    <= sclk_nxt;
      mosi    <= mosi_nxt;
      done    <= done_nxt;
      rx_byte <= rx_nxt;
    end
  end

endmodule : rbl_spi_master

// ==== rbl_boot_loader.sv ====
`timescale 1ns/10ps
module rbl_boot_loader
  import rbl_pkg::*;
#(
  parameter int SPI_HALF = SPI_HALF_CYC
) (
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic [1:0]  boot_select_pins,
  input  wire logic        soft_reset_req,
  input  wire logic        boot_bypass_cfg,
  input  wire logic        wake_req,
  input  wire logic [7:0]  flash_data_in,
  output logic             async_bank_zero_select_n,
  output logic             flash_rd_n,
  output logic [23:0]      flash_addr,
  output logic             serial_memory_select_out_n,
  output logic             spi_sclk,
  output logic             spi_mosi,
  input  wire logic        spi_miso,
  input  wire logic        host_sclk,
  input  wire logic        host_mosi,
  input  wire logic        host_cs_n,
  output logic             host_hold_flag,
  output logic [5:0]       host_hold_pin_id,
  output logic             mem_wr_en,
  output logic [31:0]      mem_addr,
  output logic [7:0]       mem_wr_data,
  output logic             exec_start,
  output logic [31:0]      exec_addr,
  output logic             exec_pack16,
  output logic [3:0]       ext_hold_cycles,
  output logic [3:0]       ext_access_cycles,
  output logic [3:0]       ext_setup_cycles,
  output logic [1:0]       boot_mode,
  output logic             boot_busy,
  output logic             boot_error
);

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic [14:0] meta_r, sync_r;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      meta_r <= 15'h0001;
      sync_r <= 15'h0001;
    end else begin
      meta_r <= {boot_select_pins, wake_req, flash_data_in, spi_miso, host_sclk, host_mosi, host_cs_n};
      sync_r <= meta_r;
    end
  end

  logic [1:0] pins_s;
  logic [7:0] flash_s;
  logic       wake_s, miso_s, hsclk_s, hmosi_s, hcs_s;
  assign pins_s  = sync_r[14:13];
  assign wake_s  = sync_r[12];
  assign flash_s = sync_r[11:4];
  assign miso_s  = sync_r[3];
  assign hsclk_s = sync_r[2];
  assign hmosi_s = sync_r[1];
  assign hcs_s   = sync_r[0];

  function automatic logic cyc_done(input logic [3:0] cnt, input logic [3:0] lim);
    cyc_done = (cnt == lim - 4'h1);
  endfunction : cyc_done

  ////////////////////////////////////////////////////////////////////////////
  // host slave receiver
  logic [7:0] hshift_r, hshift_nxt;
  logic [2:0] hbit_r, hbit_nxt;
  logic       hsclk_prev_r, wake_prev_r;
  logic       hbyte_done, wake_rise;

  assign wake_rise = wake_s && !wake_prev_r;

  always_comb begin
    hshift_nxt = hshift_r;
    hbit_nxt   = hbit_r;
    hbyte_done = 1'b0;
    if (hcs_s) begin
      hbit_nxt = 3'h0;
    end else if (hsclk_s && !hsclk_prev_r) begin
      hshift_nxt = {hshift_r[6:0], hmosi_s};
      hbit_nxt   = hbit_r + 3'h1;
      hbyte_done = (hbit_r == 3'h7);
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      hshift_r     <= 8'h00;
      hbit_r       <= 3'h0;
      hsclk_prev_r <= 1'b0;
      wake_prev_r  <= 1'b0;
    end else begin
      hshift_r     <= hshift_nxt;
      hbit_r       <= hbit_nxt;
      hsclk_prev_r <= hsclk_s;
      wake_prev_r  <= wake_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // serial memory master
  logic       spi_start, spi_done, restart;
  logic [7:0] spi_tx, spi_rx;

  rbl_spi_master #(.HALF(SPI_HALF)) u_spi (
    .clk     (clk),
    .rstn    (rstn),
    .abort   (restart),
    .start   (spi_start),
    .tx_byte (spi_tx),
    .miso_s  (miso_s),
    .done    (spi_done),
    .rx_byte (spi_rx),
    .sclk    (spi_sclk),
    .mosi    (spi_mosi)
  );

  ////////////////////////////////////////////////////////////////////////////
  // boot sequencer
  rbl_state_e  st_r, st_nxt;
  logic [1:0]  settle_r, settle_nxt, mode_nxt;
  logic        soft_r, soft_nxt, probing_r, probing_nxt, finish;
  logic [3:0]  hdr_idx_r, hdr_idx_nxt, tcnt_r, tcnt_nxt, probe_r, probe_nxt;
  logic [31:0] blk_addr_r, blk_addr_nxt, blk_cnt_r, blk_cnt_nxt;
  logic [15:0] flag_r, flag_nxt;
  logic [7:0]  byte_r, byte_nxt;
  logic        bank_n_nxt, rd_n_nxt, ss_n_nxt, wr_nxt, xs_nxt, pk_nxt, err_nxt;
  logic [23:0] fa_nxt;
  logic [31:0] ma_nxt, xa_nxt;
  logic [7:0]  md_nxt;
  logic [5:0]  pid_nxt;
  logic [3:0]  th_nxt, ta_nxt, ts_nxt;

  assign restart = soft_reset_req || wake_rise;

  always_comb begin
    st_nxt = st_r;  settle_nxt = settle_r;  mode_nxt = boot_mode;  soft_nxt = soft_r;
    probing_nxt = probing_r;  hdr_idx_nxt = hdr_idx_r;  tcnt_nxt = tcnt_r;  probe_nxt = probe_r;
    blk_addr_nxt = blk_addr_r;  blk_cnt_nxt = blk_cnt_r;  flag_nxt = flag_r;  byte_nxt = byte_r;
    bank_n_nxt = async_bank_zero_select_n;  rd_n_nxt = flash_rd_n;  ss_n_nxt = serial_memory_select_out_n;
    fa_nxt = flash_addr;  ma_nxt = mem_addr;  md_nxt = mem_wr_data;  xa_nxt = exec_addr;
    pk_nxt = exec_pack16;  pid_nxt = host_hold_pin_id;  err_nxt = boot_error;
    th_nxt = ext_hold_cycles;  ta_nxt = ext_access_cycles;  ts_nxt = ext_setup_cycles;
    wr_nxt = 1'b0;  xs_nxt = 1'b0;  finish = 1'b0;  spi_start = 1'b0;  spi_tx = PROBE_ZERO;
    case (st_r)
      S_RESET: begin
        if (settle_r == SETTLE_CYC) begin
          mode_nxt = pins_s;
          st_nxt   = S_SELECT;
        end else begin
          settle_nxt = settle_r + 2'h1;
        end
      end
      S_SELECT: begin
        hdr_idx_nxt = 4'h0;
        fa_nxt      = 24'h000000;
        if (soft_r && boot_bypass_cfg) begin
          xs_nxt = 1'b1;
          xa_nxt = L1_BASE;
          pk_nxt = 1'b0;
          st_nxt = S_DONE;
        end else begin
          if (boot_mode == MODE_DIRECT || boot_mode == MODE_FLASH) begin
            th_nxt = EXT_HOLD_CYC;
            ta_nxt = EXT_ACC_CYC;
            ts_nxt = EXT_SETUP_CYC;
          end
          case (boot_mode)
            MODE_DIRECT: begin
              xs_nxt = 1'b1;
              xa_nxt = DIRECT_ADDR;
              pk_nxt = 1'b1;
              st_nxt = S_DONE;
            end
            MODE_SPIMEM: begin
              ss_n_nxt    = 1'b0;
              spi_start   = 1'b1;
              spi_tx      = CMD_READ;
              probe_nxt   = 4'h0;
              probing_nxt = 1'b1;
              st_nxt      = S_SPI_WAIT;
            end
            default: st_nxt = S_NEXT;
          endcase
        end
      end
      S_NEXT: begin
        case (boot_mode)
          MODE_FLASH: begin
            bank_n_nxt = 1'b0;
            tcnt_nxt   = 4'h0;
            st_nxt     = S_FL_SETUP;
          end
          MODE_HOST:   st_nxt = S_HOST_WAIT;
          MODE_SPIMEM: begin
            spi_start = 1'b1;
            st_nxt    = S_SPI_WAIT;
          end
          default:     st_nxt = S_ERROR;
        endcase
      end
      S_SPI_WAIT: begin
        if (spi_done) begin
          if (!probing_r) begin
            byte_nxt = spi_rx;
            st_nxt   = S_STORE;
          end else if (probe_r != 4'h0 && spi_rx != MISO_IDLE) begin
            // first non-idle answer is header byte zero
            probing_nxt = 1'b0;
            byte_nxt    = spi_rx;
            st_nxt      = S_STORE;
          end else if (probe_r == PROBE_MAX) begin
            // error flag rises with busy falling, so a waiter sees both at once
            ss_n_nxt = 1'b1;
            err_nxt  = 1'b1;
            st_nxt   = S_ERROR;
          end else begin
            probe_nxt = probe_r + 4'h1;
            spi_start = 1'b1;
          end
        end
      end
      S_FL_SETUP: begin
        tcnt_nxt = tcnt_r + 4'h1;
        if (cyc_done(tcnt_r, ext_setup_cycles)) begin
          tcnt_nxt = 4'h0;
          rd_n_nxt = 1'b0;
          st_nxt   = S_FL_ACCESS;
        end
      end
      S_FL_ACCESS: begin
        tcnt_nxt = tcnt_r + 4'h1;
        if (cyc_done(tcnt_r, ext_access_cycles)) begin
          tcnt_nxt = 4'h0;
          byte_nxt = flash_s;
          rd_n_nxt = 1'b1;
          st_nxt   = S_FL_HOLD;
        end
      end
      S_FL_HOLD: begin
        tcnt_nxt = tcnt_r + 4'h1;
        if (cyc_done(tcnt_r, ext_hold_cycles)) begin
          bank_n_nxt = 1'b1;
          fa_nxt     = flash_addr + 24'h000001;
          st_nxt     = S_STORE;
        end
      end
      S_HOST_WAIT: begin
        if (hbyte_done) begin
          byte_nxt = hshift_nxt;
          st_nxt   = S_STORE;
        end
      end
      S_STORE: begin
        st_nxt = S_NEXT;
        if (hdr_idx_r != HDR_LEN) begin
          // header: dest addr, byte count, flag, all little endian
          hdr_idx_nxt = hdr_idx_r + 4'h1;
          if (hdr_idx_r < 4'h4) begin
            blk_addr_nxt = {byte_r, blk_addr_r[31:8]};
          end else if (hdr_idx_r < 4'h8) begin
            blk_cnt_nxt = {byte_r, blk_cnt_r[31:8]};
          end else begin
            flag_nxt = {byte_r, flag_r[15:8]};
          end
          if (hdr_idx_r == HDR_LEN - 4'h1) begin
            pid_nxt = flag_nxt[PIN_ID_MSB:PIN_ID_LSB];
            if (blk_cnt_r == 32'h0) begin
              hdr_idx_nxt = 4'h0;
              finish      = flag_nxt[FLAG_LAST_BIT];
            end
          end
        end else begin
          wr_nxt       = 1'b1;
          ma_nxt       = blk_addr_r;
          md_nxt       = byte_r;
          blk_addr_nxt = blk_addr_r + 32'h1;
          blk_cnt_nxt  = blk_cnt_r - 32'h1;
          if (blk_cnt_r == 32'h1) begin
            hdr_idx_nxt = 4'h0;
            finish      = flag_r[FLAG_LAST_BIT];
          end
        end
      end
      S_DONE:  st_nxt = S_DONE;
      S_ERROR: err_nxt = 1'b1;
      default: st_nxt = S_ERROR;
    endcase
    if (finish) begin
      xs_nxt   = 1'b1;
      xa_nxt   = L1_BASE;
      pk_nxt   = 1'b0;
      ss_n_nxt = 1'b1;
      st_nxt   = S_DONE;
    end
    if (restart) begin
      st_nxt     = S_RESET;
      settle_nxt = 2'h0;
      soft_nxt   = soft_reset_req;
      bank_n_nxt = 1'b1;
      rd_n_nxt   = 1'b1;
      ss_n_nxt   = 1'b1;
      err_nxt    = 1'b0;
      wr_nxt     = 1'b0;
      xs_nxt     = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_r <= S_RESET;  settle_r <= 2'h0;  boot_mode <= MODE_DIRECT;  soft_r <= 1'b0;
      probing_r <= 1'b0;  hdr_idx_r <= 4'h0;  tcnt_r <= 4'h0;  probe_r <= 4'h0;
      blk_addr_r <= 32'h0;  blk_cnt_r <= 32'h0;  flag_r <= 16'h0;  byte_r <= 8'h00;
      async_bank_zero_select_n <= 1'b1;  flash_rd_n <= 1'b1;  serial_memory_select_out_n <= 1'b1;
      flash_addr <= 24'h000000;  mem_addr <= 32'h0;  mem_wr_data <= 8'h00;  mem_wr_en <= 1'b0;
      exec_start <= 1'b0;  exec_addr <= 32'h0;  exec_pack16 <= 1'b0;  host_hold_pin_id <= 6'h00;
      host_hold_flag <= 1'b1;  boot_busy <= 1'b1;  boot_error <= 1'b0;
      ext_hold_cycles <= EXT_HOLD_CYC;  ext_access_cycles <= EXT_ACC_CYC;  ext_setup_cycles <= EXT_SETUP_CYC;
    end else begin
      st_r <= st_nxt;  settle_r <= settle_nxt;  boot_mode <= mode_nxt;  soft_r <= soft_nxt;
      probing_r <= probing_nxt;  hdr_idx_r <= hdr_idx_nxt;  tcnt_r <= tcnt_nxt;  probe_r <= probe_nxt;
      blk_addr_r <= blk_addr_nxt;  blk_cnt_r <= blk_cnt_nxt;  flag_r <= flag_nxt;  byte_r <= byte_nxt;
      async_bank_zero_select_n <= bank_n_nxt;  flash_rd_n <= rd_n_nxt;  serial_memory_select_out_n <= ss_n_nxt;
      flash_addr <= fa_nxt;  mem_addr <= ma_nxt;  mem_wr_data <= md_nxt;  mem_wr_en <= wr_nxt;
      exec_start <= xs_nxt;  exec_addr <= xa_nxt;  exec_pack16 <= pk_nxt;  host_hold_pin_id <= pid_nxt;
      // bytes are only taken while waiting; host must idle otherwise
      host_hold_flag <= (st_nxt != S_HOST_WAIT);
      boot_busy <= (st_nxt != S_DONE) && (st_nxt != S_ERROR);
      boot_error <= err_nxt;
      ext_hold_cycles <= th_nxt;  ext_access_cycles <= ta_nxt;  ext_setup_cycles <= ts_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  a_mode_capture: assert property (@(posedge clk) disable iff (!rstn)
    (st_r == S_RESET && settle_r == SETTLE_CYC && !restart) |=> (boot_mode == $past(pins_s)))
    else $error("mode pins not captured");
  a_direct_fetch: assert property (@(posedge clk) disable iff (!rstn)
    (st_r == S_SELECT && boot_mode == MODE_DIRECT && !(soft_r && boot_bypass_cfg) && !restart)
    |=> (exec_start && exec_addr == DIRECT_ADDR && exec_pack16))
    else $error("direct fetch wrong");
  a_slow_timing: assert property (@(posedge clk) disable iff (!rstn)
    (exec_start && exec_pack16) |-> (ext_hold_cycles == 4'h3 && ext_access_cycles == 4'hF
      && ext_setup_cycles == 4'h4))
    else $error("timing not slowest");
  a_bank_zero: assert property (@(posedge clk) disable iff (!rstn)
    $fell(flash_rd_n) |-> (!async_bank_zero_select_n && boot_mode == MODE_FLASH
      && $past(async_bank_zero_select_n, 4) == 1'b0))
    else $error("flash read outside bank zero");
  a_spi_select: assert property (@(posedge clk) disable iff (!rstn)
    !serial_memory_select_out_n |-> (boot_mode == MODE_SPIMEM))
    else $error("select in wrong mode");
  a_probe_cmd: assert property (@(posedge clk) disable iff (!rstn)
    (st_r == S_SELECT && boot_mode == MODE_SPIMEM && !soft_r && !restart)
    |-> (spi_start && spi_tx == 8'h03) ##1 (!serial_memory_select_out_n && st_r == S_SPI_WAIT))
    else $error("probe command missing");
  a_hold_busy: assert property (@(posedge clk) disable iff (!rstn)
    (st_r == S_STORE) |=> host_hold_flag)
    else $error("hold dropped while busy");
  a_pin_ident: assert property (@(posedge clk) disable iff (!rstn)
    (st_r == S_STORE && hdr_idx_r == 4'h9 && !restart)
    |=> (host_hold_pin_id == $past({byte_r[2:0], flag_r[15:13]})))
    else $error("hold pin id wrong");
  a_mem_write: assert property (@(posedge clk) disable iff (!rstn)
    (st_r == S_STORE && hdr_idx_r == HDR_LEN && !restart)
    |=> (mem_wr_en && mem_addr == $past(blk_addr_r) && mem_wr_data == $past(byte_r)))
    else $error("block byte not written");
  a_l1_start: assert property (@(posedge clk) disable iff (!rstn)
    (exec_start && !exec_pack16) |-> (exec_addr == 32'hFFA0_0000))
    else $error("loader exec address wrong");
  a_por_nobypass: assert property (@(posedge clk) disable iff (!rstn)
    (st_r == S_SELECT && !soft_r && boot_mode != MODE_DIRECT && !restart) |=> !exec_start)
    else $error("bypass on power-on reset");
  a_wake_restart: assert property (@(posedge clk) disable iff (!rstn)
    wake_rise |=> (st_r == S_RESET && !soft_r) ##4 (st_r != S_RESET || restart))
    else $error("wake did not restart boot");

endmodule : rbl_boot_loader

// ==== rbl_far_side.sv ====
`timescale 1ns/10ps
module rbl_far_side
  import rbl_pkg::*;
#(
  parameter int SKIP = 3
) (
  input  wire logic        clk,
  input  wire logic        bank_n,
  input  wire logic        rd_n,
  input  wire logic [23:0] faddr,
  output logic      [7:0]  fdata,
  input  wire logic        cs_n,
  input  wire logic        sclk,
  input  wire logic        mosi,
  output logic             miso,
  output logic      [7:0]  cmd_seen
);
  logic [7:0] img [0:63];
  logic [7:0] rx;
  logic [7:0] cur;
  logic       tog = 1'b0;
  int         bitc = 0;
  int         byt = 0;
  int         skip = SKIP;
  ////////////////////////////////////////////////////////////////////////
  always @(posedge clk) tog <= ~tog;
  // released bus toggles so a stale byte never looks valid
  assign fdata = (!bank_n && !rd_n) ? img[faddr[5:0]] : {8{tog}};
  ////////////////////////////////////////////////////////////////////////
  // probe bytes answer idle, then the image follows
  function automatic logic [7:0] resp(input int n);
    return (n <= skip) ? 8'hFF : img[(n - skip - 1) & 63];
  endfunction : resp
  always @(negedge cs_n) begin
    bitc = 0;
    byt = 0;
  end
  always @(posedge sclk) begin
    rx = {rx[6:0], mosi};
    if (!cs_n && bitc == 7 && byt == 0) cmd_seen = rx;
  end
  always @(negedge sclk) begin
    if (!cs_n) begin
      byt = (bitc == 7) ? byt + 1 : byt;
      bitc = (bitc + 1) % 8;
    end
  end
  assign cur = resp(byt);
  assign miso = cs_n ? tog : cur[7 - bitc];
endmodule : rbl_far_side

// ==== rbl_boot_loader_bench.sv ====
`timescale 1ns/10ps
module rbl_boot_loader_bench import rbl_pkg::*;;
  logic        clk = 1'b0;
  logic        rstn, soft_reset_req, boot_bypass_cfg, wake_req, host_sclk, host_mosi, host_cs_n, spi_miso;
  logic        async_bank_zero_select_n, flash_rd_n, serial_memory_select_out_n, spi_sclk, spi_mosi;
  logic        host_hold_flag, mem_wr_en, exec_start, exec_pack16, boot_error, boot_busy;
  logic [1:0]  boot_select_pins, boot_mode;
  logic [7:0]  flash_data_in, cmd_seen, mem_wr_data;
  logic [23:0] flash_addr;
  logic [5:0]  host_hold_pin_id, pid;
  logic [31:0] mem_addr, exec_addr;
  logic [3:0]  ext_hold_cycles, ext_access_cycles, ext_setup_cycles;
  logic [31:0] exp_a [0:31];
  logic [7:0]  exp_d [0:31];
  int          bad_count, checks_done, ne, nimg, wi, n_exec, cyc, k;
  integer      seed;
  ////////////////////////////////////////////////////////////////////////
  rbl_boot_loader #(.SPI_HALF(4)) DUT (.clk, .rstn, .boot_select_pins, .soft_reset_req, .boot_bypass_cfg,
    .wake_req, .flash_data_in, .async_bank_zero_select_n, .flash_rd_n, .flash_addr, .serial_memory_select_out_n,
    .spi_sclk, .spi_mosi, .spi_miso, .host_sclk, .host_mosi, .host_cs_n, .host_hold_flag, .host_hold_pin_id,
    .mem_wr_en, .mem_addr, .mem_wr_data, .exec_start, .exec_addr, .exec_pack16, .ext_hold_cycles,
    .ext_access_cycles, .ext_setup_cycles, .boot_mode, .boot_busy, .boot_error);
  rbl_far_side #(.SKIP(3)) mem (.clk, .bank_n(async_bank_zero_select_n), .rd_n(flash_rd_n), .faddr(flash_addr),
    .fdata(flash_data_in), .cs_n(serial_memory_select_out_n), .sclk(spi_sclk), .mosi(spi_mosi), .miso(spi_miso),
    .cmd_seen);
  always #5 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////
  task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask : chk
  task finish_test;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : finish_test
  task tick;
    @(posedge clk);
    #1;
  endtask : tick
  task put(input logic [7:0] v);
    mem.img[nimg] = v;
    nimg++;
  endtask : put
  // two blocks, the first may carry no data at all
  task build;
    logic [31:0] a, c;
    logic [15:0] f;
    int          b, j;
    nimg = 0;
    ne = 0;
    pid = 6'($random(seed));
    for (b = 0; b < 2; b++) begin
      a = L1_BASE + ($random(seed) & 32'h0000_0FF0);
      c = (b == 0) ? ($random(seed) & 3) : 2;
      f = {(b == 1), 4'h0, pid, 5'h00};
      for (j = 0; j < 4; j++) put(a[8*j +: 8]);
      for (j = 0; j < 4; j++) put(c[8*j +: 8]);
      put(f[7:0]);
      put(f[15:8]);
      for (j = 0; j < c; j++) begin
        exp_a[ne] = a + j;
        exp_d[ne] = 8'($random(seed));
        put(exp_d[ne]);
        ne++;
      end
    end
  endtask : build
  task por(input logic [1:0] m);
    rstn = 1'b0;
    boot_select_pins = m;
    wi = 0;
    n_exec = 0;
    repeat (3) @(posedge clk);
    chk(host_hold_flag, 1, "hold in reset");
    #1 rstn = 1'b1;
  endtask : por
  task wait_boot(input logic [31:0] ea, input int nw, input string name);
    int i;
    for (i = 0; i < 6000 && n_exec == 0; i++) tick;
    chk(n_exec, 1, "start pulse");
    chk(boot_busy, 0, "busy flag");
    chk(exec_addr, ea, "start address");
    chk(wi, nw, "write count");
    chk(boot_error, 0, "error flag");
    $display("test %s done", name);
  endtask : wait_boot
  // host side must not send while the hold flag is up
  task host_byte(input logic [7:0] b);
    int i;
    for (i = 0; i < 400 && host_hold_flag !== 1'b0; i++) tick;
    host_cs_n = 1'b0;
    for (i = 7; i >= 0; i--) begin
      host_mosi = b[i];
      repeat (4) tick;
      host_sclk = 1'b1;
      repeat (4) tick;
      host_sclk = 1'b0;
    end
    host_mosi = ~b[0];
    for (i = 0; i < 50 && host_hold_flag !== 1'b1; i++) tick;
  endtask : host_byte
  ////////////////////////////////////////////////////////////////////////
  always @(posedge clk) begin
    cyc++;
    if (exec_start === 1'b1) n_exec++;
    if (mem_wr_en === 1'b1) begin
      chk(mem_addr, exp_a[wi & 31], "write address");
      chk(mem_wr_data, exp_d[wi & 31], "write data");
      wi++;
    end
    if (cyc == 20000) begin
      bad_count++;
      $display("unexpected at %0t: run too long", $time);
      finish_test;
    end
  end
  initial begin
    seed = 32'h55E1;
    {rstn, soft_reset_req, wake_req, host_sclk, host_mosi} = 5'h00;
    {host_cs_n, boot_bypass_cfg} = 2'h3;
    {bad_count, checks_done, cyc} = 96'h0;
    build;
    // bypass bit set at power-on must not matter
    por(MODE_DIRECT);
    wait_boot(DIRECT_ADDR, 0, "direct");
    chk(exec_pack16, 1, "packing");
    chk({ext_hold_cycles, ext_access_cycles, ext_setup_cycles}, 12'h3F4, "bus timing");
    chk(boot_mode, MODE_DIRECT, "mode");
    boot_bypass_cfg = 1'b0;
    por(MODE_FLASH);
    wait_boot(L1_BASE, ne, "flash");
    chk({ext_hold_cycles, ext_access_cycles, ext_setup_cycles}, 12'h3F4, "bus timing");
    chk(exec_pack16, 0, "packing");
    chk(host_hold_pin_id, pid, "hold pin");
    chk(boot_mode, MODE_FLASH, "mode");
    {boot_bypass_cfg, soft_reset_req, wi, n_exec} = {2'h3, 64'h0};
    tick;
    soft_reset_req = 1'b0;
    wait_boot(L1_BASE, 0, "soft bypass");
    {wake_req, wi, n_exec} = {1'b1, 64'h0};
    wait_boot(L1_BASE, ne, "wake");
    {wake_req, boot_bypass_cfg} = 2'h0;
    build;
    por(MODE_SPIMEM);
    wait_boot(L1_BASE, ne, "serial memory");
    chk(cmd_seen, CMD_READ, "read command");
    chk(serial_memory_select_out_n, 1, "select released");
    chk(boot_mode, MODE_SPIMEM, "mode");
    // memory that never answers: probe limit, then error
    mem.skip = 20;
    por(MODE_SPIMEM);
    for (k = 0; k < 2000 && boot_busy !== 1'b0; k++) tick;
    chk(boot_error, 1, "no memory error");
    chk(mem.byt, PROBE_MAX + 4'h1, "probe bytes");
    chk(n_exec, 0, "no start");
    chk(serial_memory_select_out_n, 1, "select released");
    $display("test no memory done");
    build;
    por(MODE_HOST);
    for (k = 0; k < nimg; k++) host_byte(mem.img[k]);
    host_cs_n = 1'b1;
    wait_boot(L1_BASE, ne, "spi host");
    chk(host_hold_pin_id, pid, "hold pin");
    finish_test;
  end
endmodule : rbl_boot_loader_bench
